// >>> src/psled_cfg.svh
// Constants for the status indicator driver: offsets, field positions,
// reset values and timing counts. Assumes a 20 MHz core clock.
`ifndef PSLED_CFG_SVH
`define PSLED_CFG_SVH

// Register byte offsets on the bus
`define PSLED_OFS_POL       8'h44
`define PSLED_OFS_DRIVE     8'h38
`define PSLED_OFS_MODE      8'h74
`define PSLED_OFS_BEHAV     8'h78
`define PSLED_OFS_STATUS    8'h80
`define PSLED_OFS_PORTID    8'h84

// Field positions
`define PSLED_POL_LO        10
`define PSLED_POL_HI        13
`define PSLED_DRIVE_BIT     9
`define PSLED_TXONLY_BIT    14

// Reset values
`define PSLED_POL_RST       4'h0
`define PSLED_DRIVE_RST     1'b1
`define PSLED_MODE_RST      8'h10
`define PSLED_BEHAV_RST     16'h0000

// Timing: core clock and base periods
`define PSLED_CLK_HZ        20000000
`define PSLED_BLINK_HALF_MS 25
`define PSLED_STRETCH_MS    50
`define PSLED_BLINK_CYC     ((`PSLED_CLK_HZ / 1000) * `PSLED_BLINK_HALF_MS)
`define PSLED_STRETCH_CYC   ((`PSLED_CLK_HZ / 1000) * `PSLED_STRETCH_MS)
`define PSLED_SER_DIV       10

`endif

// >>> src/psled_pkg.sv
// Types shared by the status indicator driver.
// Needs no cfg header: all its numbers are literals.
`default_nettype none
package psled_pkg;
  typedef enum logic [3:0] {
    PSLED_M_LINK_ACT   = 4'h0,
    PSLED_M_L1000      = 4'h1,
    PSLED_M_L100       = 4'h2,
    PSLED_M_L10        = 4'h3,
    PSLED_M_L100_1000  = 4'h4,
    PSLED_M_L10_1000   = 4'h5,
    PSLED_M_L10_100    = 4'h6,
    PSLED_M_RSV7       = 4'h7,
    PSLED_M_DUPLEX     = 4'h8,
    PSLED_M_COLL       = 4'h9,
    PSLED_M_ACT        = 4'ha,
    PSLED_M_RSV11      = 4'hb,
    PSLED_M_ANFAULT    = 4'hc,
    PSLED_M_SERIAL     = 4'hd,
    PSLED_M_OFF        = 4'he,
    PSLED_M_ON         = 4'hf
  } psled_mode_t;

  typedef enum logic [1:0] {
    PSLED_S_IDLE  = 2'b00,
    PSLED_S_LOW   = 2'b01,
    PSLED_S_HIGH  = 2'b10
  } psled_ser_t;
endpackage : psled_pkg
`default_nettype wire

// >>> src/psled_pin.sv
// One indicator lane: turns a raw indicator level, activity and the lane's
// behaviour settings into an asserted/blinking level. Same clock as caller.
`default_nettype none
`include "psled_cfg.svh"
module psled_pin (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       primary,
  input  wire logic       event_in,
  input  wire logic       event_only,
  input  wire logic       combine,
  input  wire logic       blink_en,
  input  wire logic       stretch_sel,
  input  wire logic [1:0] rate,
  input  wire logic       blink_phase_0,
  input  wire logic       blink_phase_1,
  input  wire logic       blink_phase_2,
  input  wire logic       blink_phase_3,
  input  wire logic       tick_50ms,
  output logic            lit
);
  logic [3:0] str_cnt_q;
  logic [3:0] str_len;
  logic       stretched;
  logic       phase;
  logic       shown_evt;

  // Stretch length counts 50 ms ticks: 1, 2, 4 or 8
  assign str_len   = 4'h1 << rate;
  assign stretched = (str_cnt_q != 4'h0);
  assign phase     = (rate == 2'd0) ? blink_phase_0 : (rate == 2'd1) ? blink_phase_1 :
                     (rate == 2'd2) ? blink_phase_2 : blink_phase_3;
  // Events only show when behaviour settings allow it
  assign shown_evt = blink_en & (stretch_sel ? stretched : (event_in & phase));

  // Stretch counter restarts on every event
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      str_cnt_q <= 4'h0;
    end else if (event_in) begin
      str_cnt_q <= str_len;
    end else if (stretched && tick_50ms) begin
      str_cnt_q <= str_cnt_q - 4'h1;
    end
  end

  // Link lane shows activity as a blank only when combined
  always_comb begin
    if (event_only) begin
      lit = shown_evt;
    end else if (combine && blink_en) begin
      lit = primary & ~shown_evt;
    end else begin
      lit = primary;
    end
  end
endmodule : psled_pin
`default_nettype wire

// >>> src/psled_top.sv
// Status indicator driver: direct drive of two indicator pins or a
// continuous serial status stream. Registers on AHB-Lite, status inputs
// arrive from the PHY core asynchronously and are synchronised here.
`default_nettype none
`include "psled_cfg.svh"

module psled_top (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        link_1000,
  input  wire logic        link_100,
  input  wire logic        link_10,
  input  wire logic        full_duplex,
  input  wire logic        collision,
  input  wire logic        tx_activity,
  input  wire logic        rx_activity,
  input  wire logic        an_fault,
  input  wire logic        port_is_zero,
  input  wire logic        reset_blink_req,
  output logic             indicator_pin_a_o,
  output logic             indicator_pin_a_oe,
  output logic             indicator_pin_b_o,
  output logic             indicator_pin_b_oe
);
  // Synchronisers for asynchronous status inputs
  logic [9:0] st_s1_q;
  logic [9:0] st_s2_q;
  logic       rblink_prev_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_s1_q <= 10'h000;
      st_s2_q <= 10'h000;
    end else begin
      st_s1_q <= {reset_blink_req, port_is_zero, an_fault, rx_activity, tx_activity,
                  collision, full_duplex, link_10, link_100, link_1000};
      st_s2_q <= st_s1_q;
    end
  end
  wire l1000 = st_s2_q[0];
  wire l100  = st_s2_q[1];
  wire l10   = st_s2_q[2];
  wire fdx   = st_s2_q[3];
  wire coll  = st_s2_q[4];
  wire txa   = st_s2_q[5];
  wire rxa   = st_s2_q[6];
  wire anf   = st_s2_q[7];
  wire port0 = st_s2_q[8];
  wire rblnk = st_s2_q[9];

  // Registers
  logic [3:0]  pol_q;
  logic        drive_q;
  logic [7:0]  mode_q;
  logic [15:0] behav_q;

  // AHB-Lite address phase capture; zero wait states
  logic       wr_pend_q;
  logic [7:0] addr_q;
  wire        take = hsel & hready & htrans[1];
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_pend_q <= 1'b0;
      addr_q    <= 8'h00;
    end else begin
      wr_pend_q <= take & hwrite;
      addr_q    <= take ? haddr[7:0] : addr_q;
    end
  end

  // Register writes land in the data phase
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pol_q   <= `PSLED_POL_RST;
      drive_q <= `PSLED_DRIVE_RST;
      mode_q  <= `PSLED_MODE_RST;
      behav_q <= `PSLED_BEHAV_RST;
    end else if (wr_pend_q) begin
      case (addr_q)
        `PSLED_OFS_POL:   pol_q   <= hwdata[`PSLED_POL_HI:`PSLED_POL_LO];
        `PSLED_OFS_DRIVE: drive_q <= hwdata[`PSLED_DRIVE_BIT];
        `PSLED_OFS_MODE:  mode_q  <= hwdata[7:0];
        `PSLED_OFS_BEHAV: behav_q <= hwdata[15:0];
        default:          ;
      endcase
    end
  end

  // Read mux decides the next data phase value
  logic [31:0] rd_d;
  logic [31:0] rd_q;
  always_comb begin
    case (haddr[7:0])
      `PSLED_OFS_POL:    rd_d = {18'h00000, pol_q, 10'h000};
      `PSLED_OFS_DRIVE:  rd_d = {22'h000000, drive_q, 9'h000};
      `PSLED_OFS_MODE:   rd_d = {24'h000000, mode_q};
      `PSLED_OFS_BEHAV:  rd_d = {16'h0000, behav_q};
      `PSLED_OFS_STATUS: rd_d = {22'h000000, st_s2_q};
      default:           rd_d = 32'h00000000;
    endcase
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_q <= 32'h00000000;
    end else if (take && !hwrite) begin
      rd_q <= rd_d;
    end
  end
  assign hrdata    = rd_q;
  assign hreadyout = 1'b1; // Never stalls: all accesses are single cycle
  assign hresp     = 1'b0;

  // Shared time base: 50 ms tick and four blink phase dividers
  logic [20:0] blk_cnt_q;
  logic [20:0] str_cnt_q;
  logic [3:0]  phase_q;
  wire         blk_tick = (blk_cnt_q == 21'(`PSLED_BLINK_CYC - 1));
  wire         tick_50  = (str_cnt_q == 21'(`PSLED_STRETCH_CYC - 1));
  logic [2:0]  halfs_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      blk_cnt_q <= 21'h000000;
      str_cnt_q <= 21'h000000;
      halfs_q   <= 3'h0;
      phase_q   <= 4'h0;
    end else begin
      blk_cnt_q <= blk_tick ? 21'h000000 : blk_cnt_q + 21'h000001;
      str_cnt_q <= tick_50 ? 21'h000000 : str_cnt_q + 21'h000001;
      if (blk_tick) begin
        halfs_q <= halfs_q + 3'h1;
        // 20 Hz half period 25 ms, then 10, 5, 2.5 Hz
        phase_q <= {(halfs_q == 3'h7) ? ~phase_q[3] : phase_q[3],
                    (halfs_q[1:0] == 2'h3) ? ~phase_q[2] : phase_q[2],
                    halfs_q[0] ? ~phase_q[1] : phase_q[1], ~phase_q[0]};
      end
    end
  end

  // Post-reset blink window: one second of 2.5 Hz unless forced modes
  logic [4:0] rb_cnt_q;
  wire        rb_active = (rb_cnt_q != 5'h00);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rb_cnt_q      <= 5'h00;
      rblink_prev_q <= 1'b0;
    end else begin
      rblink_prev_q <= rblnk;
      if (rblnk && !rblink_prev_q) begin
        rb_cnt_q <= 5'd20;
      end else if (rb_active && tick_50) begin
        rb_cnt_q <= rb_cnt_q - 5'h01;
      end
    end
  end

  // Per mode level and event; status is an argument so continuous callers follow it
  wire [7:0] stat_v = {anf, rxa, txa, coll, fdx, l10, l100, l1000};
  function automatic logic [2:0] psled_decode(input logic [3:0] m, input logic tx_only, input logic [7:0] s);
    logic any_link;
    logic act;
    any_link = s[0] | s[1] | s[2];
    act      = s[5] | s[6];
    case (psled_pkg::psled_mode_t'(m))
      psled_pkg::PSLED_M_LINK_ACT:  psled_decode = {any_link, any_link & act, 1'b0};
      psled_pkg::PSLED_M_L1000:     psled_decode = {s[0], s[0] & act, 1'b0};
      psled_pkg::PSLED_M_L100:      psled_decode = {s[1], s[1] & act, 1'b0};
      psled_pkg::PSLED_M_L10:       psled_decode = {s[2], s[2] & act, 1'b0};
      psled_pkg::PSLED_M_L100_1000: psled_decode = {s[1] | s[0], (s[1] | s[0]) & act, 1'b0};
      psled_pkg::PSLED_M_L10_1000:  psled_decode = {s[2] | s[0], (s[2] | s[0]) & act, 1'b0};
      psled_pkg::PSLED_M_L10_100:   psled_decode = {s[2] | s[1], (s[2] | s[1]) & act, 1'b0};
      psled_pkg::PSLED_M_DUPLEX:    psled_decode = {any_link & s[3], any_link & ~s[3] & s[4], 1'b0};
      psled_pkg::PSLED_M_COLL:      psled_decode = {1'b0, s[4], 1'b1};
      psled_pkg::PSLED_M_ACT:       psled_decode = {1'b0, tx_only ? s[5] : act, 1'b1};
      psled_pkg::PSLED_M_ANFAULT:   psled_decode = {s[7], 1'b0, 1'b0};
      psled_pkg::PSLED_M_ON:        psled_decode = 3'b100;
      default:                      psled_decode = 3'b000;
    endcase
  endfunction : psled_decode

  // Behaviour layout per pin byte: [0] combine, [1] blink en, [2] stretch, [4:3] rate
  wire [3:0] mode_a  = mode_q[3:0];
  wire [3:0] mode_b  = mode_q[7:4];
  wire       tx_only = behav_q[`PSLED_TXONLY_BIT];
  wire       ser_en  = (mode_a == 4'hd) & port0;

  // Direct lanes and serial lanes share the lane module
  logic [1:0]  dir_lit;
  logic [11:0] ser_lit;
  genvar gi;
  generate
    for (gi = 0; gi < 14; gi++) begin : g_lane
      logic [2:0] dec;
      logic [7:0] bh;
      if (gi < 2) begin : g_dir
        assign dec = psled_decode(gi == 0 ? mode_a : mode_b, tx_only, stat_v);
        assign bh  = behav_q[gi*8 +: 8];
      end else begin : g_ser
        // Stream slot order: link modes, duplex, collision, activity, tx, rx, fault
        localparam logic [3:0] SLOT_MODE [12] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h7, 4'h8,
                                                 4'h9, 4'ha, 4'hb, 4'ha, 4'ha, 4'hc};
        wire [2:0] base = psled_decode(SLOT_MODE[gi-2], gi == 11, stat_v);
        assign dec = (gi == 12) ? {1'b0, rxa, 1'b1} : base;
        assign bh  = behav_q[7:0];
      end
      logic lit;
      psled_pin u_pin (
        .clk           (clk),
        .arst_n        (arst_n),
        .primary       (dec[2]),
        .event_in      (dec[1]),
        .event_only    (dec[0]),
        .combine       (bh[0]),
        .blink_en      (bh[1]),
        .stretch_sel   (bh[2]),
        .rate          (bh[4:3]),
        .blink_phase_0 (phase_q[3]),
        .blink_phase_1 (phase_q[2]),
        .blink_phase_2 (phase_q[1]),
        .blink_phase_3 (phase_q[0]),
        .tick_50ms     (tick_50),
        .lit           (lit)
      );
      if (gi < 2) begin : g_do
        assign dir_lit[gi] = lit;
      end else begin : g_so
        assign ser_lit[gi-2] = lit;
      end
    end
  endgenerate

  // Forced modes suppress the post-reset blink
  wire [1:0] forced = {mode_b[3:1] == 3'h7, mode_a[3:1] == 3'h7};
  wire [1:0] lit_f  = {(rb_active & ~forced[1]) ? phase_q[3] : dir_lit[1],
                       (rb_active & ~forced[0]) ? phase_q[3] : dir_lit[0]};

  // Serial engine: clock low half, then high half, per bit
  psled_pkg::psled_ser_t st_q;
  logic [3:0]  div_q;
  logic [3:0]  bit_q;
  logic [11:0] shf_q;
  logic        sclk_q;
  logic        sdat_q;
  wire         div_end = (div_q == 4'(`PSLED_SER_DIV - 1));
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q   <= psled_pkg::PSLED_S_IDLE;
      div_q  <= 4'h0;
      bit_q  <= 4'h0;
      shf_q  <= 12'h000;
      sclk_q <= 1'b0;
      sdat_q <= 1'b0;
    end else begin
      div_q <= (div_end || st_q == psled_pkg::PSLED_S_IDLE) ? 4'h0 : div_q + 4'h1;
      case (st_q)
        psled_pkg::PSLED_S_IDLE: begin
          sclk_q <= 1'b0;
          if (ser_en) begin
            st_q  <= psled_pkg::PSLED_S_LOW;
            shf_q <= ser_lit;
            bit_q <= 4'h0;
          end
        end
        psled_pkg::PSLED_S_LOW: begin
          sclk_q <= 1'b0;
          sdat_q <= shf_q[0];
          if (div_end) begin
            st_q <= psled_pkg::PSLED_S_HIGH;
          end
        end
        psled_pkg::PSLED_S_HIGH: begin
          sclk_q <= 1'b1;
          if (div_end) begin
            shf_q <= (bit_q == 4'd11) ? ser_lit : {1'b0, shf_q[11:1]};
            bit_q <= (bit_q == 4'd11) ? 4'h0 : bit_q + 4'h1;
            st_q  <= ser_en ? psled_pkg::PSLED_S_LOW : psled_pkg::PSLED_S_IDLE;
          end
        end
        default: st_q <= psled_pkg::PSLED_S_IDLE;
      endcase
    end
  end

  // Pin drivers: polarity, drive style, serial takeover
  logic a_o_q, a_oe_q, b_o_q, b_oe_q;
  wire  a_lvl = lit_f[0] ~^ pol_q[0];
  wire  b_lvl = lit_f[1] ~^ pol_q[1];
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      a_o_q  <= 1'b0;
      a_oe_q <= 1'b0;
      b_o_q  <= 1'b0;
      b_oe_q <= 1'b0;
    end else if (ser_en) begin
      a_o_q  <= sdat_q;
      a_oe_q <= 1'b1;
      b_o_q  <= sclk_q;
      b_oe_q <= 1'b1;
    end else begin
      a_o_q  <= a_lvl;
      a_oe_q <= ~a_lvl | ~drive_q;
      b_o_q  <= b_lvl;
      b_oe_q <= ~b_lvl | ~drive_q;
    end
  end
  assign indicator_pin_a_o  = a_o_q;
  assign indicator_pin_a_oe = a_oe_q;
  assign indicator_pin_b_o  = b_o_q;
  assign indicator_pin_b_oe = b_oe_q;

  // Checks
  AST_FORCE_ON: assert property (@(posedge clk) disable iff (!arst_n)
    (mode_a == 4'hf && !ser_en && !rb_active && pol_q[0] == 1'b0) [*2] |=> (indicator_pin_a_o == 1'b0))
    else $error("forced-on pin A not asserted");
  AST_FLOAT: assert property (@(posedge clk) disable iff (!arst_n)
    (drive_q && !ser_en && a_lvl) |=> !indicator_pin_a_oe)
    else $error("inactive pin A driven in float mode");
  AST_SER_OE: assert property (@(posedge clk) disable iff (!arst_n)
    ser_en |=> (indicator_pin_a_oe && indicator_pin_b_oe))
    else $error("serial pins not driven");
  AST_SER_EN: assert property (@(posedge clk) disable iff (!arst_n)
    (st_q == psled_pkg::PSLED_S_IDLE && ser_en) |=> (st_q == psled_pkg::PSLED_S_LOW))
    else $error("serial engine did not start");
  AST_DATA_STABLE: assert property (@(posedge clk) disable iff (!arst_n)
    (st_q == psled_pkg::PSLED_S_HIGH) |=> $stable(sdat_q))
    else $error("serial data moved while clock high");
  AST_FRAME_WRAP: assert property (@(posedge clk) disable iff (!arst_n)
    (st_q == psled_pkg::PSLED_S_HIGH && div_end && bit_q == 4'd11) |=> (bit_q == 4'h0))
    else $error("frame did not wrap after twelve bits");
  AST_PORT_ONLY: assert property (@(posedge clk) disable iff (!arst_n)
    !port0 |=> (indicator_pin_a_o == $past(a_lvl)))
    else $error("serial data on pin A of a non-zero port");
  AST_POL: assert property (@(posedge clk) disable iff (!arst_n)
    (!ser_en && $stable(a_lvl)) |=> (indicator_pin_a_o == $past(a_lvl)))
    else $error("pin A level mismatch");
endmodule : psled_top
`default_nettype wire

// >>> dv/psled_led_rx.sv
// Far-side model: pulled-up indicator pins and a serial status receiver.
// Assumes pin levels arrive already resolved from drive and enable.
`default_nettype none
module psled_led_rx (
  input  wire logic   pin_a,
  input  wire logic   pin_b,
  output logic [23:0] bits_q,
  output int          nbits
);
  timeunit 1ns;
  timeprecision 1ns;

  // Start empty so the bench counts only fresh bits
  initial begin
    bits_q = '0;
    nbits  = 0;
  end

  // Data taken on the serial clock's rising edge only
  always @(posedge pin_b) begin
    bits_q <= {bits_q[22:0], pin_a};
    nbits  <= nbits + 1;
  end
endmodule : psled_led_rx
`default_nettype wire

// >>> dv/testbench.sv
// Self-checking bench for the status indicator driver.
// Assumes the design's cfg header and the indicator model file.
`default_nettype none
`include "psled_cfg.svh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH %s exp=%h got=%h", nm, e, g); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        arst_n, hsel, hwrite;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hreadyout, hresp;
  logic [9:0]  st;
  logic        pa_o, pa_oe, pb_o, pb_oe, pa_w, pb_w;
  logic [23:0] bits;
  logic [3:0]  ma, mb;
  logic [1:0]  pol;
  logic        drv;
  logic [31:0] r;
  int          nbits, t0;
  int          n_mismatch = 0;
  int          num_checks = 0;
  int          cycles = 0;
  int          seed = 20582;
  logic [3:0]  modes [13] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'ha, 4'hc, 4'he, 4'hf};

  // Clock and pulled-up pin levels
  always #25 clk = ~clk;
  assign pa_w = pa_oe ? pa_o : 1'b1;
  assign pb_w = pb_oe ? pb_o : 1'b1;

  psled_top psled_top_inst (
    .clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .link_1000(st[0]), .link_100(st[1]), .link_10(st[2]), .full_duplex(st[3]),
    .collision(st[4]), .tx_activity(st[5]), .rx_activity(st[6]), .an_fault(st[7]),
    .port_is_zero(st[8]), .reset_blink_req(st[9]), .indicator_pin_a_o(pa_o),
    .indicator_pin_a_oe(pa_oe), .indicator_pin_b_o(pb_o), .indicator_pin_b_oe(pb_oe));

  psled_led_rx psled_led_rx_inst (.pin_a(pa_w), .pin_b(pb_w), .bits_q(bits), .nbits(nbits));

  // Expected lit state of a direct pin, steady status only
  function automatic logic lit_of(input logic [3:0] m, input logic [9:0] s);
    logic lk;
    lk = |s[2:0];
    case (m)
      4'h0: return lk;
      4'h1: return s[0];
      4'h2: return s[1];
      4'h3: return s[2];
      4'h4: return s[0] | s[1];
      4'h5: return s[2] | s[0];
      4'h6: return s[2] | s[1];
      4'h8: return s[3] & lk;
      4'hc: return s[7];
      4'hf: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : lit_of

  // Expected serial frame, first slot (link/activity) in the top bit
  function automatic logic [11:0] ser_exp(input logic [9:0] s);
    logic lk;
    lk = |s[2:0];
    return {lk, s[0], s[1], s[2], 1'b0, s[3] & lk, s[4], s[5] | s[6], 1'b0, s[5], s[6], s[7]};
  endfunction : ser_exp

  // No frame marker on the wire, so any rotation of the frame is accepted
  function automatic logic rot_ok(input logic [11:0] w, input logic [11:0] e);
    logic ok;
    logic [11:0] x;
    ok = 1'b0;
    x = e;
    for (int k = 0; k < 12; k++) begin
      if (w === x) ok = 1'b1;
      x = {x[10:0], x[11]};
    end
    return ok;
  endfunction : rot_ok

  // One AHB-Lite single word transfer
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= 3'b010;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask : ahb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d, rdv);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0, rdv);
    `CHK("reg_read", e, rdv)
    `CHK("hresp", 1'b0, hresp)
  endtask : rd_chk

  // Direct pin: low level always pulls to ground, high level floats unless drive state is 0
  task automatic chk_pin(input logic [3:0] m, input logic p, input logic d, input logic o, input logic oe);
    logic l;
    logic v;
    l = lit_of(m, st);
    v = l ? p : ~p;
    `CHK("pin_oe", ~v | ~d, oe)
    if (~v | ~d) `CHK("pin_level", v, o)
  endtask : chk_pin

  task automatic wait_bits(input int n);
    int s;
    s = nbits;
    while (nbits < s + n) @(posedge clk);
  endtask : wait_bits

  task automatic conclude();
    if (n_mismatch == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  // Hang guard, well above the expected run length
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      conclude();
    end
  end

  // Main sequence
  initial begin
    arst_n = 1'b0; hsel = 1'b0; haddr = '0; htrans = '0; hwrite = 1'b0; hsize = 3'b010;
    hwdata = '0; st = 10'h100;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    // Reset values and an unmapped place
    rd_chk(`PSLED_OFS_POL, 32'h0);
    rd_chk(`PSLED_OFS_DRIVE, 32'h200);
    rd_chk(`PSLED_OFS_MODE, 32'h10);
    rd_chk(`PSLED_OFS_BEHAV, 32'h0);
    wr(8'h10, 32'hffff_ffff);
    rd_chk(8'h10, 32'h0);
    // Random status, modes, polarity and drive state on both pins
    for (int i = 0; i < 40; i++) begin
      r = $random(seed);
      ma = modes[r[19:16] % 13];
      mb = modes[r[27:24] % 13];
      pol = r[21:20];
      drv = r[22];
      st <= {2'b01, r[7], 3'b000, r[3:0]};
      wr(`PSLED_OFS_POL, {18'h0, pol, 10'h0});
      wr(`PSLED_OFS_DRIVE, {22'h0, drv, 9'h0});
      wr(`PSLED_OFS_MODE, {24'h0, mb, ma});
      repeat (6) @(posedge clk);
      chk_pin(ma, pol[0], drv, pa_o, pa_oe);
      chk_pin(mb, pol[1], drv, pb_o, pb_oe);
      rd_chk(`PSLED_OFS_STATUS, {22'h0, st});
    end
    // Transmit-only activity ignores receive traffic
    wr(`PSLED_OFS_DRIVE, 32'h0);
    wr(`PSLED_OFS_BEHAV, 32'h4006);
    wr(`PSLED_OFS_MODE, 32'h0a);
    st <= 10'h141;
    repeat (8) @(posedge clk);
    for (int i = 0; i < 20; i++) begin
      repeat (5) @(posedge clk);
      chk_pin(4'ha, pol[0], 1'b0, pa_o, pa_oe);
    end
    // A transmit event starts a stretch that lights pin A
    st <= 10'h121;
    repeat (8) @(posedge clk);
    `CHK("act_stretch", pol[0], pa_o)
    // Serial stream on port 0, two status patterns
    wr(`PSLED_OFS_BEHAV, 32'h0);
    st <= 10'h189;
    wr(`PSLED_OFS_MODE, 32'h1d);
    wait_bits(24);
    `CHK("serial_frame", 1'b1, rot_ok(bits[11:0], ser_exp(st)))
    @(posedge pb_w);
    @(negedge clk);
    t0 = cycles;
    @(posedge pb_w);
    @(negedge clk);
    `CHK("serial_period", 20, cycles - t0)
    st <= 10'h104;
    wait_bits(36);
    `CHK("serial_frame", 1'b1, rot_ok(bits[11:0], ser_exp(st)))
    // Serial code on another port is reserved: no serial clock
    st <= 10'h004;
    repeat (20) @(posedge clk);
    t0 = nbits;
    repeat (100) @(posedge clk);
    `CHK("serial_idle", t0, nbits)
    // Forced modes hold steady through a post-reset blink request
    wr(`PSLED_OFS_POL, 32'h0);
    wr(`PSLED_OFS_MODE, 32'hef);
    st <= 10'h301;
    repeat (8) @(posedge clk);
    for (int i = 0; i < 40; i++) begin
      repeat (5) @(posedge clk);
      chk_pin(4'hf, 1'b0, 1'b0, pa_o, pa_oe);
      chk_pin(4'he, 1'b0, 1'b0, pb_o, pb_oe);
    end
    conclude();
  end
endmodule : testbench
`default_nettype wire
